// [hw/dcf_pkg.sv]
// Shared constants and types for the deep FIFO with programmable flags
package dcf_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int DATA_W = 9;
    localparam int ADDR_W_SMALL = 16;
    localparam int ADDR_W_LARGE = 17;
    localparam int OFFSET_REG_W = 9;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [8:0] OFFSET_LO_DEFAULT = 9'h007;
    localparam logic [8:0] OFFSET_HI_DEFAULT = 9'h000;
    localparam logic [8:0] DATA_RESET = 9'h000;

    // ------------------------------------------------------------
    // Offset register selection, rotating order
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SEL_EMPTY_LO = 4'b0001,
        SEL_EMPTY_HI = 4'b0010,
        SEL_FULL_LO = 4'b0100,
        SEL_FULL_HI = 4'b1000
    } dcf_offset_sel_e;

    // ------------------------------------------------------------
    // Status flags, all active low
    // ------------------------------------------------------------
    typedef struct packed {
        logic emptyN;
        logic almostEmptyN;
        logic almostFullN;
        logic fullN;
    } dcf_flags_s;

    localparam dcf_flags_s FLAGS_RESET = '{
        emptyN: 1'b0,
        almostEmptyN: 1'b0,
        almostFullN: 1'b1,
        fullN: 1'b1
    };

endpackage

// [hw/dcf_fifo_prog_flags.sv]
// Deep FIFO, nine-bit words, with empty, full and programmable partial flags
`timescale 1ns/1ps

module dcf_fifo_prog_flags #(
    parameter bit largeVariant = 1'b0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic fifo_reset_n,
    // Write side
    input wire logic write_en_primary_n,
    input wire logic write_en_second_or_load,
    input wire logic [dcf_pkg::DATA_W-1:0] write_data,
    // Read side
    input wire logic read_en_a_n,
    input wire logic read_en_b_n,
    input wire logic output_en_n,
    output logic [dcf_pkg::DATA_W-1:0] read_data,
    output logic readDataOe,
    // Status
    output dcf_pkg::dcf_flags_s flags,
    output logic loadModeActive
);

    // ------------------------------------------------------------
    // Sizing
    // ------------------------------------------------------------
    // Address width from the chosen variant
    localparam int AW = largeVariant ? dcf_pkg::ADDR_W_LARGE : dcf_pkg::ADDR_W_SMALL;
    // Bits kept in the high offset registers
    localparam int HI_W = AW - dcf_pkg::OFFSET_REG_W;
    // Full depth, one bit wider than an address
    localparam logic [AW:0] DEPTH = {1'b1, {AW{1'b0}}};
    // Mask for high offset writes
    localparam logic [8:0] HI_MASK = 9'({HI_W{1'b1}});

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [dcf_pkg::DATA_W-1:0] mem [0:(1<<AW)-1];
    // Write and read pointers, one wrap bit above the address
    logic [AW:0] wrPtr_r;
    logic [AW:0] wrPtr_nxt;
    logic [AW:0] rdPtr_r;
    logic [AW:0] rdPtr_nxt;
    // Offset registers
    logic [8:0] emptyLo_r;
    logic [8:0] emptyLo_nxt;
    logic [8:0] emptyHi_r;
    logic [8:0] emptyHi_nxt;
    logic [8:0] fullLo_r;
    logic [8:0] fullLo_nxt;
    logic [8:0] fullHi_r;
    logic [8:0] fullHi_nxt;
    // Offset selection and mode caught at reset
    dcf_pkg::dcf_offset_sel_e sel_r;
    dcf_pkg::dcf_offset_sel_e sel_nxt;
    logic loadMode_r;
    logic loadMode_nxt;
    // Output data register
    logic [dcf_pkg::DATA_W-1:0] readData_r;
    logic [dcf_pkg::DATA_W-1:0] readData_nxt;
    // Status flags
    dcf_pkg::dcf_flags_s flags_r;
    dcf_pkg::dcf_flags_s flags_nxt;

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    logic inReset;
    logic readReq;
    logic bufWrite;
    logic bufRead;
    logic offsetWrite;
    logic offsetRead;
    logic [AW:0] countNxt;
    logic [AW-1:0] emptyOffset;
    logic [AW-1:0] fullOffset;

    // Either reset source empties the buffer
    assign inReset = reset | ~fifo_reset_n;
    // Both read enables must be low
    assign readReq = ~read_en_a_n & ~read_en_b_n;
    // Buffer write needs both write enables and a not-full buffer, whatever the mode
    assign bufWrite = ~inReset & ~write_en_primary_n & write_en_second_or_load
                      & flags_r.fullN;
    // Offset access only in load mode with the pin low
    assign offsetWrite = ~inReset & loadMode_r & ~write_en_primary_n
                         & ~write_en_second_or_load;
    assign offsetRead = ~inReset & loadMode_r & ~write_en_second_or_load
                        & readReq;
    // Offset read wins over a buffer read
    assign bufRead = ~inReset & readReq & ~offsetRead & flags_r.emptyN;
    // Thresholds n and m from their register pairs
    assign emptyOffset = {emptyHi_r[HI_W-1:0], emptyLo_r};
    assign fullOffset = {fullHi_r[HI_W-1:0], fullLo_r};

    // ------------------------------------------------------------
    // Pointers and mode
    // ------------------------------------------------------------
    always_comb begin
        wrPtr_nxt = wrPtr_r;
        rdPtr_nxt = rdPtr_r;
        loadMode_nxt = loadMode_r;
        if (inReset) begin
            wrPtr_nxt = '0;
            rdPtr_nxt = '0;
            loadMode_nxt = ~write_en_second_or_load;
        end else begin
            if (bufWrite) begin
                wrPtr_nxt = wrPtr_r + 1'b1;
            end
            if (bufRead) begin
                rdPtr_nxt = rdPtr_r + 1'b1;
            end
        end
    end

    // Single clock: both pointers live in one domain, no crossing needed
    assign countNxt = wrPtr_nxt - rdPtr_nxt;

    // ------------------------------------------------------------
    // Fill level compare
    // ------------------------------------------------------------
    logic [AW:0] emptyMark;
    logic [AW:0] fullMark;
    logic levelNonEmpty;
    logic levelAboveEmpty;
    logic levelBelowFull;
    logic levelNotFull;

    // Threshold n at pointer width
    assign emptyMark = {1'b0, emptyOffset};
    // Threshold depth minus m
    assign fullMark = DEPTH - {1'b0, fullOffset};
    // Level tests on the next occupancy
    assign levelNonEmpty = (countNxt != '0);
    assign levelAboveEmpty = (countNxt > emptyMark);
    assign levelBelowFull = (countNxt < fullMark);
    assign levelNotFull = (countNxt != DEPTH);

    // ------------------------------------------------------------
    // Offset registers and selection pointer
    // ------------------------------------------------------------
    always_comb begin
        emptyLo_nxt = emptyLo_r;
        emptyHi_nxt = emptyHi_r;
        fullLo_nxt = fullLo_r;
        fullHi_nxt = fullHi_r;
        sel_nxt = sel_r;
        if (inReset) begin
            emptyLo_nxt = dcf_pkg::OFFSET_LO_DEFAULT;
            emptyHi_nxt = dcf_pkg::OFFSET_HI_DEFAULT;
            fullLo_nxt = dcf_pkg::OFFSET_LO_DEFAULT;
            fullHi_nxt = dcf_pkg::OFFSET_HI_DEFAULT;
            sel_nxt = dcf_pkg::SEL_EMPTY_LO;
        end else if (offsetWrite || offsetRead) begin
            unique case (sel_r)
                dcf_pkg::SEL_EMPTY_LO: begin
                    if (offsetWrite) begin
                        emptyLo_nxt = write_data;
                    end
                    sel_nxt = dcf_pkg::SEL_EMPTY_HI;
                end
                dcf_pkg::SEL_EMPTY_HI: begin
                    if (offsetWrite) begin
                        emptyHi_nxt = write_data & HI_MASK;
                    end
                    sel_nxt = dcf_pkg::SEL_FULL_LO;
                end
                dcf_pkg::SEL_FULL_LO: begin
                    if (offsetWrite) begin
                        fullLo_nxt = write_data;
                    end
                    sel_nxt = dcf_pkg::SEL_FULL_HI;
                end
                dcf_pkg::SEL_FULL_HI: begin
                    if (offsetWrite) begin
                        fullHi_nxt = write_data & HI_MASK;
                    end
                    sel_nxt = dcf_pkg::SEL_EMPTY_LO; // Wrap
                end
            endcase
        end
        // Otherwise the selection holds for the next burst
    end

    // ------------------------------------------------------------
    // Output data register
    // ------------------------------------------------------------
    always_comb begin
        readData_nxt = readData_r; // Hold last word when empty
        if (inReset) begin
            readData_nxt = dcf_pkg::DATA_RESET;
        end else if (offsetRead) begin
            unique case (sel_r)
                dcf_pkg::SEL_EMPTY_LO: begin
                    readData_nxt = emptyLo_r;
                end
                dcf_pkg::SEL_EMPTY_HI: begin
                    readData_nxt = emptyHi_r;
                end
                dcf_pkg::SEL_FULL_LO: begin
                    readData_nxt = fullLo_r;
                end
                dcf_pkg::SEL_FULL_HI: begin
                    readData_nxt = fullHi_r;
                end
            endcase
        end else if (bufRead) begin
            readData_nxt = mem[rdPtr_r[AW-1:0]];
        end
    end

    // ------------------------------------------------------------
    // Status flags from the next fill level
    // ------------------------------------------------------------
    always_comb begin
        flags_nxt = flags_r;
        if (inReset) begin
            flags_nxt = dcf_pkg::FLAGS_RESET;
        end else begin
            flags_nxt.emptyN = levelNonEmpty;
            flags_nxt.almostEmptyN = levelAboveEmpty;
            flags_nxt.almostFullN = levelBelowFull;
            flags_nxt.fullN = levelNotFull;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Pointers and mode
    always_ff @(posedge clk_sys) begin
        wrPtr_r <= wrPtr_nxt;
        rdPtr_r <= rdPtr_nxt;
        loadMode_r <= loadMode_nxt;
    end

    // Offset registers and their selection
    always_ff @(posedge clk_sys) begin
        emptyLo_r <= emptyLo_nxt;
        emptyHi_r <= emptyHi_nxt;
        fullLo_r <= fullLo_nxt;
        fullHi_r <= fullHi_nxt;
        sel_r <= sel_nxt;
    end

    // Output data register
    always_ff @(posedge clk_sys) begin
        readData_r <= readData_nxt;
    end

    // Status flags
    always_ff @(posedge clk_sys) begin
        flags_r <= flags_nxt; // Registered, so each level lasts a cycle
    end

    // ------------------------------------------------------------
    // Storage array
    // ------------------------------------------------------------
    // Write port, no reset
    always_ff @(posedge clk_sys) begin
        if (bufWrite) begin
            mem[wrPtr_r[AW-1:0]] <= write_data;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Output register, always driven
    assign read_data = readData_r;
    // Three-state control for the data pads
    assign readDataOe = ~output_en_n;
    // Registered status and mode
    assign flags = flags_r;
    assign loadModeActive = loadMode_r;

endmodule // dcf_fifo_prog_flags

// [testbench/dcf_fifo_asserts.sv]
// Port-level checker for the deep FIFO
`timescale 1ns/1ps
module dcf_fifo_asserts #(
    parameter bit largeVariant = 1'b0
) (
    // Clock and reset
    input logic clk_sys,
    input logic reset,
    input logic fifo_reset_n,
    // Write side
    input logic write_en_primary_n,
    input logic write_en_second_or_load,
    input logic [dcf_pkg::DATA_W-1:0] write_data,
    // Read side
    input logic read_en_a_n,
    input logic read_en_b_n,
    input logic output_en_n,
    input logic [dcf_pkg::DATA_W-1:0] read_data,
    input logic readDataOe,
    // Status
    input dcf_pkg::dcf_flags_s flags,
    input logic loadModeActive
);
    // ----
    // Decoded requests
    // ----
    logic rstAny;
    logic wrReq;
    logic rdReq;
    logic rdBuf;
    assign rstAny = reset | ~fifo_reset_n;
    assign wrReq = ~write_en_primary_n & write_en_second_or_load;
    assign rdReq = ~read_en_a_n & ~read_en_b_n;
    assign rdBuf = rdReq & ~(loadModeActive & ~write_en_second_or_load);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rstAny);
    sequence s_release; $fell(rstAny); endsequence
    sequence s_eightWr; s_release ##0 (wrReq & ~rdReq) [*8]; endsequence
    property p_oe; readDataOe == !output_en_n; endproperty
    property p_rst; s_release |-> flags == dcf_pkg::FLAGS_RESET && read_data == 9'h000; endproperty
    property p_mode; s_release |-> loadModeActive == !$past(write_en_second_or_load); endproperty
    property p_dflt; s_eightWr |-> !flags.almostEmptyN ##1 flags.almostEmptyN; endproperty
    property p_wr1; !flags.emptyN && wrReq && !rdReq |=> flags.emptyN; endproperty
    property p_ehold; !loadModeActive && !flags.emptyN && rdReq |=> $stable(read_data); endproperty
    property p_frefuse; !flags.fullN && wrReq && !rdBuf |=> !flags.fullN; endproperty
    property p_fleave; !flags.fullN && rdBuf && !wrReq |=> flags.fullN; endproperty
    property p_ldkeep; loadModeActive && !write_en_second_or_load && !flags.emptyN |=> !flags.emptyN; endproperty
    a_oe: assert property (p_oe) else $error("output enable wrong");
    a_rst: assert property (p_rst) else $error("reset state wrong");
    a_mode: assert property (p_mode) else $error("mode pick wrong");
    a_dflt: assert property (p_dflt) else $error("default threshold wrong");
    a_wr1: assert property (p_wr1) else $error("write lost");
    a_ehold: assert property (p_ehold) else $error("empty read moved data");
    a_frefuse: assert property (p_frefuse) else $error("full left on write");
    a_fleave: assert property (p_fleave) else $error("full kept after read");
    a_ldkeep: assert property (p_ldkeep) else $error("load access wrote buffer");
endmodule // dcf_fifo_asserts
bind dcf_fifo_prog_flags dcf_fifo_asserts #(.largeVariant(largeVariant)) u_asserts (
    .clk_sys(clk_sys), .reset(reset), .fifo_reset_n(fifo_reset_n),
    .write_en_primary_n(write_en_primary_n), .write_en_second_or_load(write_en_second_or_load),
    .write_data(write_data), .read_en_a_n(read_en_a_n), .read_en_b_n(read_en_b_n),
    .output_en_n(output_en_n), .read_data(read_data), .readDataOe(readDataOe),
    .flags(flags), .loadModeActive(loadModeActive));

// [testbench/dcf_bus_keeper.sv]
// Consumer-side model of the three-state read bus
`timescale 1ns/1ps
module dcf_bus_keeper (
    // Device side
    input wire logic clk_sys,
    input wire logic [dcf_pkg::DATA_W-1:0] read_data,
    input wire logic readDataOe,
    // Consumer side
    output logic [dcf_pkg::DATA_W-1:0] busWord
);
    logic [dcf_pkg::DATA_W-1:0] lastWord = 9'h000;
    // Keep the last driven word; a released bus shows its inverse
    always @(posedge clk_sys) begin
        if (readDataOe) lastWord <= read_data;
    end
    assign busWord = readDataOe ? read_data : ~lastWord;
endmodule // dcf_bus_keeper

// [testbench/dcf_fifo_prog_flags_test.sv]
// Self-checking bench for the deep FIFO
`timescale 1ns/1ps
module dcf_fifo_prog_flags_test;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [8:0] d;
        logic [8:0] q;
        logic [3:0] f;
    } dcf_row_s;
    logic clk_sys, reset, fifo_reset_n, write_en_primary_n, write_en_second_or_load;
    logic read_en_a_n, read_en_b_n, output_en_n, readDataOe, loadModeActive;
    logic [8:0] write_data, read_data, busWord;
    dcf_pkg::dcf_flags_s flags;
    dcf_row_s rows [19];
    logic [8:0] offs [4] = '{9'h002, 9'h000, 9'h003, 9'h000};
    int err_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    dcf_fifo_prog_flags #(.largeVariant(1'b0)) DUT (.clk_sys(clk_sys), .reset(reset),
        .fifo_reset_n(fifo_reset_n), .write_en_primary_n(write_en_primary_n),
        .write_en_second_or_load(write_en_second_or_load), .write_data(write_data),
        .read_en_a_n(read_en_a_n), .read_en_b_n(read_en_b_n), .output_en_n(output_en_n),
        .read_data(read_data), .readDataOe(readDataOe), .flags(flags),
        .loadModeActive(loadModeActive));
    dcf_bus_keeper u_keeper (.clk_sys(clk_sys), .read_data(read_data),
        .readDataOe(readDataOe), .busWord(busWord));
    // Clock and hang guard
    initial begin
        clk_sys = 0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 67000) begin
            err_count++;
            test_done();
        end
    end
    task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("BAD %s exp %h got %h", name, exp, got);
            err_count++;
        end
    endtask
    // One cycle of enables and data
    task automatic step(input logic wr, input logic rd, input logic [8:0] d);
        write_en_primary_n = !wr;
        read_en_a_n = !rd;
        read_en_b_n = !rd;
        write_data = d;
        @(negedge clk_sys);
    endtask
    task automatic rst(input logic pin);
        write_en_second_or_load = pin;
        reset = 1;
        step(0, 0, 9'h000);
        repeat (7) @(negedge clk_sys);
        reset = 0;
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        int cnt;
        output_en_n = 0;
        fifo_reset_n = 1;
        for (int i = 0; i < 19; i++) begin
            cnt = (i < 9) ? ((i < 8) ? i + 1 : 8) : ((i < 16) ? 16 - i : 0);
            rows[i] = '{i < 9, i > 7, 9'(i + 1), (i < 8) ? 9'h000 : ((i < 17) ? 9'(i - 7) : 9'h009),
                {cnt != 0, cnt > 7, 2'b11}};
        end
        rst(1);
        for (int i = 0; i < 19; i++) begin
            step(rows[i].wr, rows[i].rd, rows[i].d);
            chk("rowData", rows[i].q, read_data);
            chk("rowFlags", 9'(rows[i].f), 9'(flags));
        end
        output_en_n = 1;
        step(0, 0, 9'h000);
        chk("busReleased", 9'h000, 9'(busWord === read_data));
        output_en_n = 0;
        rst(0);
        chk("loadMode", 9'h001, 9'(loadModeActive));
        step(1, 0, 9'h002);
        write_en_second_or_load = 1;
        step(0, 0, 9'h000);
        write_en_second_or_load = 0;
        step(1, 0, 9'h000);
        step(1, 0, 9'h003);
        step(1, 0, 9'h000);
        chk("noBufWrite", 9'h000, 9'(flags.emptyN));
        for (int i = 0; i < 4; i++) begin
            step(0, 1, 9'h000);
            chk("offsetRead", offs[i], read_data);
        end
        write_en_second_or_load = 1;
        for (int i = 1; i <= 65537; i++) begin
            step(1, 0, 9'(i));
            if (i == 2 || i == 3) chk("almostEmpty", 9'(i == 3), 9'(flags.almostEmptyN));
            if (i == 1000) chk("middle", 9'h00f, 9'(flags));
            if (i == 65532 || i == 65533) chk("almostFull", 9'(i == 65532), 9'(flags.almostFullN));
            if (i >= 65535) chk("full", 9'(i == 65535), 9'(flags.fullN));
        end
        step(0, 1, 9'h000);
        chk("firstWord", 9'h001, read_data);
        fifo_reset_n = 0;
        step(0, 0, 9'h000);
        fifo_reset_n = 1;
        chk("resetFlags", 9'(dcf_pkg::FLAGS_RESET), 9'(flags));
        chk("resetData", 9'h000, read_data);
        chk("dualMode", 9'h000, 9'(loadModeActive));
        test_done();
    end
endmodule // dcf_fifo_prog_flags_test
